//--- verilog/ppfs_pkg.sv
// Package for the pump PWM and fail-safe control block
package ppfs_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SETTING = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_FAULT = 8'h10;
    // Control field positions
    localparam int CTRL_PUMP_EN = 0;
    localparam int CTRL_FS_ON = 1;
    localparam int CTRL_FS_AUTO_OFF = 2;
    localparam int CTRL_THR_LO = 4;
    // Setting field positions
    localparam int SET_PERIOD_LO = 0;
    localparam int SET_DUTY_LO = 8;
    // Service fault bit of the pump short
    localparam int FAULT_PUMP_SHORT = 11;
    // Status event bits
    localparam int EV_SHORT = 0;
    localparam int EV_PERIOD = 1;
    // Reset values
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [1:0] RST_THR = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;
    // Decoding limits
    localparam logic [7:0] PERIOD_MIN_SETTING = 8'h08;
    localparam logic [8:0] PERIOD_MIN_TICKS = 9'h009;
    localparam logic [7:0] DUTY_FULL = 8'h80;
    localparam int DUTY_STEPS = 128;
    // Base tick: 6,25 us, since 9 ticks give 56,25 us
    localparam int BASE_TICK_NS = 6250;
    localparam int CLK_PERIOD_NS = 8;
    localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
    // Short detection blank time, least figure
    localparam int BLANK_US = 7;
    localparam int BLANK_CYCLES = (BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // Settings carried as one unit
    typedef struct packed {
        logic [7:0] period;
        logic [7:0] duty;
    } ppfs_pwm_cfg_t;
endpackage

//--- verilog/ppfs_pwm_core.sv
// PWM generator with base tick divider and period-start setting load
module ppfs_pwm_core
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic run_in,
    input wire ppfs_pkg::ppfs_pwm_cfg_t cfg_in,
    output logic pwm_out,
    output logic period_start_out
);
    import ppfs_pkg::*;

    // Ticks per period from the period setting
    function automatic logic [8:0] period_ticks(input logic [7:0] s);
        if (s < PERIOD_MIN_SETTING)
            period_ticks = PERIOD_MIN_TICKS;
        else
            period_ticks = {1'b0, s} + 9'h001;
    endfunction

    logic [15:0] div_count;
    logic tick;
    logic [15:0] sub_count;
    logic [8:0] tick_count;
    ppfs_pwm_cfg_t active;
    logic [23:0] on_cycles;
    logic [23:0] pos;

    // Base tick divider
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !run_in)
            div_count <= 16'h0000;
        else if (div_count == 16'(BASE_TICK_CYCLES - 1))
            div_count <= 16'h0000;
        else
            div_count <= div_count + 16'h0001;
    end
    assign tick = run_in && (div_count == 16'(BASE_TICK_CYCLES - 1));

    // Tick counter within the period
    // period in base ticks
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !run_in)
            tick_count <= 9'h000;
        else if (tick)
        begin
            if (tick_count == period_ticks(active.period) - 9'h001)
                tick_count <= 9'h000;
            else
                tick_count <= tick_count + 9'h001;
        end
    end

    // Period start marker
    assign period_start_out = run_in && (div_count == 16'h0000) && (tick_count == 9'h000);

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            active <= '{period: RST_PERIOD, duty: RST_DUTY};
        else if (!run_in || period_start_out)
            active <= cfg_in;
    end

    always_comb
    begin
        pos = 24'(tick_count) * 24'(BASE_TICK_CYCLES) + 24'(div_count);
        if (active.duty >= DUTY_FULL)
            on_cycles = 24'hff_ffff;
        else
            on_cycles = 24'((32'(period_ticks(active.period)) * 32'(BASE_TICK_CYCLES)
                * 32'(active.duty)) / DUTY_STEPS);
    end

    // Registered gate waveform
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !run_in)
            pwm_out <= 1'b0;
        else
            pwm_out <= (pos < on_cycles);
    end

    property p_full_on;
        @(posedge clock_in) disable iff (reset_in)
        (run_in && active.duty >= DUTY_FULL) ##1 run_in |-> pwm_out;
    endproperty
    a_full_on: assert property (p_full_on) else $error("gate not full on");

    property p_zero_duty;
        @(posedge clock_in) disable iff (reset_in)
        (active.duty == 8'h00) |=> !pwm_out;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("gate on at zero duty");

    property p_stable_mid;
        @(posedge clock_in) disable iff (reset_in)
        (run_in && $past(run_in) && !$past(period_start_out)) |-> $stable(active);
    endproperty
    a_stable_mid: assert property (p_stable_mid) else $error("settings changed mid period");

    property p_min_period;
        @(posedge clock_in) disable iff (reset_in)
        tick_count <= period_ticks(active.period) - 9'h001;
    endproperty
    a_min_period: assert property (p_min_period) else $error("tick count beyond period");
endmodule

//--- verilog/ppfs_top.sv
// Pump PWM pre-driver and fail-safe switch control with AXI4-Lite registers
module ppfs_top
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic short_detect_in,
    output logic [1:0] short_threshold_code_out,
    output logic pump_gate_output_out,
    output logic failsafe_gate_output_out,
    output logic interrupt_output_pin_out
);
    import ppfs_pkg::*;

    logic pump_en;
    logic fs_on;
    logic fs_auto_off;
    logic [1:0] thr_code;
    ppfs_pwm_cfg_t cfg;
    logic [1:0] status;
    logic [1:0] mask;
    logic fault;
    logic short_meta;
    logic short_sync;
    logic [15:0] blank_count;
    logic detect;
    logic pwm;
    logic period_start;
    logic run;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic do_read;
    logic fault_read;
    logic [31:0] read_word;
    logic read_ok;

    // Write address and data capture, either order
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end
    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
    assign do_write = aw_held && w_held && !s_axi_bvalid_out;

    // Write response
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= AXI_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (aw_addr[7:2] <= REG_FAULT[7:2]) ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
    end

    // Control and setting registers, byte lanes honoured
    // threshold code select
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            pump_en <= 1'b0;
            fs_on <= 1'b0;
            fs_auto_off <= 1'b0;
            thr_code <= RST_THR;
            cfg <= '{period: RST_PERIOD, duty: RST_DUTY};
            mask <= RST_MASK;
        end
        else if (do_write)
        begin
            if (aw_addr[7:2] == REG_CTRL[7:2] && w_strb[0])
            begin
                pump_en <= w_data[CTRL_PUMP_EN];
                fs_on <= w_data[CTRL_FS_ON];
                fs_auto_off <= w_data[CTRL_FS_AUTO_OFF];
                thr_code <= w_data[CTRL_THR_LO +: 2];
            end
            if (aw_addr[7:2] == REG_SETTING[7:2])
            begin
                if (w_strb[0])
                    cfg.period <= w_data[SET_PERIOD_LO +: 8];
                if (w_strb[1])
                    cfg.duty <= w_data[SET_DUTY_LO +: 8];
            end
            if (aw_addr[7:2] == REG_MASK[7:2] && w_strb[0])
                mask <= w_data[1:0];
        end
    end

    // Read channel
    assign do_read = s_axi_arvalid_in && s_axi_arready_out;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    always_comb
    begin
        read_word = 32'h0000_0000;
        read_ok = 1'b1;
        case (s_axi_araddr_in[7:2])
            REG_CTRL[7:2]:
            begin
                read_word[CTRL_PUMP_EN] = pump_en;
                read_word[CTRL_FS_ON] = fs_on;
                read_word[CTRL_FS_AUTO_OFF] = fs_auto_off;
                read_word[CTRL_THR_LO +: 2] = thr_code;
            end
            REG_SETTING[7:2]:
            begin
                read_word[SET_PERIOD_LO +: 8] = cfg.period;
                read_word[SET_DUTY_LO +: 8] = cfg.duty;
            end
            REG_STATUS[7:2]: read_word[1:0] = status;
            REG_MASK[7:2]: read_word[1:0] = mask;
            REG_FAULT[7:2]: read_word[FAULT_PUMP_SHORT] = fault;
            default: read_ok = 1'b0;
        endcase
    end
    assign fault_read = do_read && (s_axi_araddr_in[7:2] == REG_FAULT[7:2]);

    // Read data held until taken
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= AXI_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= read_word;
            s_axi_rresp_out <= read_ok ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
    end

    // Short comparator input synchroniser
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            short_meta <= 1'b0;
            short_sync <= 1'b0;
        end
        else
        begin
            short_meta <= short_detect_in;
            short_sync <= short_meta;
        end
    end

    // Blank time after each gate turn-on
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !pwm)
            blank_count <= 16'h0000;
        else if (blank_count != 16'(BLANK_CYCLES))
            blank_count <= blank_count + 16'h0001;
    end

    assign detect = pump_en && pwm && short_sync && (blank_count == 16'(BLANK_CYCLES));

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            fault <= 1'b0;
        else if (detect)
            fault <= 1'b1;
        else if (fault_read)
            fault <= 1'b0;
    end

    // Sticky events, write one clears, set wins
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            status <= 2'b00;
        else
        begin
            if (do_write && aw_addr[7:2] == REG_STATUS[7:2] && w_strb[0])
                status <= (status & ~w_data[1:0]);
            if (detect)
                status[EV_SHORT] <= 1'b1;
            if (period_start)
                status[EV_PERIOD] <= 1'b1;
        end
    end

    assign interrupt_output_pin_out = |(status & mask);

    assign run = pump_en && !fault;

    ppfs_pwm_core u_core
    (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .run_in(run),
        .cfg_in(cfg),
        .pwm_out(pwm),
        .period_start_out(period_start)
    );

    assign pump_gate_output_out = pwm && !fault && !detect;
    assign short_threshold_code_out = thr_code;
    assign failsafe_gate_output_out = fs_on && !(fs_auto_off && fault);

    property p_gate_off;
        @(posedge clock_in) disable iff (reset_in)
        fault |-> !pump_gate_output_out;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate on during fault");

    property p_latch;
        @(posedge clock_in) disable iff (reset_in)
        (fault && !fault_read) |=> fault;
    endproperty
    a_latch: assert property (p_latch) else $error("fault dropped without read");

    property p_set;
        @(posedge clock_in) disable iff (reset_in)
        detect |=> fault && status[EV_SHORT];
    endproperty
    a_set: assert property (p_set) else $error("short not latched");

    property p_enable_only;
        @(posedge clock_in) disable iff (reset_in)
        (!pump_en && !fault) |=> !fault;
    endproperty
    a_enable_only: assert property (p_enable_only) else $error("detect while disabled");

    property p_resume;
        @(posedge clock_in) disable iff (reset_in)
        ($fell(fault) && pump_en) |-> (run && period_start);
    endproperty
    a_resume: assert property (p_resume) else $error("no restart after clear");

    property p_failsafe;
        @(posedge clock_in) disable iff (reset_in)
        !fault |-> failsafe_gate_output_out == fs_on;
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("fail-safe not as commanded");

    property p_fs_off;
        @(posedge clock_in) disable iff (reset_in)
        (fault && fs_auto_off) |-> !failsafe_gate_output_out;
    endproperty
    a_fs_off: assert property (p_fs_off) else $error("fail-safe on in fault");

    property p_irq;
        @(posedge clock_in) disable iff (reset_in)
        (detect && mask[EV_SHORT]) |=> interrupt_output_pin_out;
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt on short");

    property p_thr;
        @(posedge clock_in) disable iff (reset_in)
        short_threshold_code_out == thr_code;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold code mismatch");
endmodule

//--- tb/ppfs_fet_model.sv
// Behavioural external pump FET with its drain-source comparator
module ppfs_fet_model
(
    input wire logic gate_in,
    input wire logic short_in,
    output logic vds_high_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Drain-source reads high when off, and when shorted while on
    always_comb
    begin
        vds_high_out = short_in || !gate_in;
    end
endmodule

//--- tb/test_ppfs_top.sv
// Self-checking bench for the pump PWM and fail-safe block
module test_ppfs_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ppfs_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic short_cmd = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, vds, gate, fs, irq;
    logic [1:0] bresp, rresp, thr;
    logic [31:0] rdata;
    int fail_count = 0;
    int compares = 0;
    int per, hi, exp_hi, ticks;
    int pset[3] = '{7, 8, 9};
    int dset[3] = '{32, 64, 127};

    // Clock at 125 MHz
    always #4 clock_in = ~clock_in;

    ppfs_top u_ppfs_top (.clock_in(clock_in), .reset_in(reset_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .short_detect_in(vds),
        .short_threshold_code_out(thr), .pump_gate_output_out(gate),
        .failsafe_gate_output_out(fs), .interrupt_output_pin_out(irq));

    ppfs_fet_model u_ppfs_fet_model (.gate_in(gate), .short_in(short_cmd), .vds_high_out(vds));

    // Verdict and end of run
    task automatic summarize;
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Wait limit ran out
    task automatic hang;
        fail_count++;
        $display("[FAIL] %0t wait limit reached", $time);
        summarize();
    endtask

    // Register write, checks the response code
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        @(posedge clock_in);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb)
        begin
            @(negedge clock_in);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb)
                chk({30'h0, bresp}, {30'h0, r}, "write resp");
            @(posedge clock_in);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            n++;
            if (n > 50)
                hang();
        end
        bready <= 1'b0;
    endtask

    // Register read, checks data and response code
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge clock_in);
            ta = arvalid && arready;
            tr = rvalid;
            if (tr)
            begin
                chk(rdata, d, "read data");
                chk({30'h0, rresp}, {30'h0, r}, "read resp");
            end
            @(posedge clock_in);
            if (ta)
                arvalid <= 1'b0;
            n++;
            if (n > 50)
                hang();
        end
        rready <= 1'b0;
    endtask

    // Measure one gate period and its high time; without skip it waits for a fresh rise
    task automatic meas(input bit skip, output int p, output int h);
        int n;
        n = 0;
        p = 0;
        h = 0;
        while (!skip && gate !== 1'b0 && n < 20000)
        begin
            @(negedge clock_in);
            n++;
        end
        while (!skip && gate !== 1'b1 && n < 20000)
        begin
            @(negedge clock_in);
            n++;
        end
        while (gate === 1'b1 && n < 40000)
        begin
            h++;
            n++;
            @(negedge clock_in);
        end
        while (gate !== 1'b1 && n < 40000)
        begin
            p++;
            n++;
            @(negedge clock_in);
        end
        p += h;
        if (n >= 40000)
            hang();
    endtask

    // Gate high samples over a stretch
    task automatic count_high(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(negedge clock_in);
            h += (gate === 1'b1) ? 1 : 0;
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clock_in);
        reset_in <= 1'b0;
        // Reset values, unmapped place
        for (int i = 0; i < 5; i++)
            axi_rd(8'(4 * i), 32'h0000_0000, AXI_OKAY);
        chk({29'h0, gate, fs, irq}, 32'h0000_0000, "idle outputs");
        axi_rd(8'h14, 32'h0000_0000, AXI_SLVERR);
        axi_wr(8'h14, 32'hffff_ffff, AXI_SLVERR);
        axi_rd(REG_CTRL, 32'h0000_0000, AXI_OKAY);
        $display("test reset done");
        // Every threshold code and the fail-safe command
        for (int i = 0; i < 4; i++)
        begin
            axi_wr(REG_CTRL, 32'(i) << CTRL_THR_LO, AXI_OKAY);
            chk({30'h0, thr}, 32'(i), "threshold");
        end
        axi_wr(REG_CTRL, 32'h0000_0002, AXI_OKAY);
        chk({31'h0, fs}, 32'h0000_0001, "failsafe on");
        axi_wr(REG_CTRL, 32'h0000_0000, AXI_OKAY);
        chk({31'h0, fs}, 32'h0000_0000, "failsafe off");
        $display("test config done");
        // Period and duty decoding at the lower boundary
        axi_wr(REG_SETTING, 32'h0000_2007, AXI_OKAY);
        axi_wr(REG_CTRL, 32'h0000_0001, AXI_OKAY);
        for (int i = 0; i < 3; i++)
        begin
            ticks = (pset[i] < 8) ? 9 : pset[i] + 1;
            exp_hi = ticks * BASE_TICK_CYCLES * dset[i] / 128;
            axi_wr(REG_SETTING, 32'(dset[i] * 256 + pset[i]), AXI_OKAY);
            meas(1'b0, per, hi);
            chk(32'(per), 32'(ticks * BASE_TICK_CYCLES), "period");
            chk({31'h0, hi >= exp_hi - 1 && hi <= exp_hi + 1}, 32'h0000_0001, "on time");
        end
        // New settings mid-period must not cut the running period
        axi_wr(REG_SETTING, 32'h0000_0108, AXI_OKAY);
        meas(1'b1, per, hi);
        chk({31'h0, hi > 7700 && per > 7750}, 32'h0000_0001, "period cut");
        axi_wr(REG_SETTING, 32'h0000_0008, AXI_OKAY);
        repeat (7900) @(posedge clock_in);
        count_high(7100, hi);
        chk(32'(hi), 32'h0000_0000, "duty zero");
        $display("test pwm done");
        // Interrupt raised, masked and cleared by period events
        axi_wr(REG_MASK, 32'h0000_0000, AXI_OKAY);
        chk({31'h0, irq}, 32'h0000_0000, "masked irq");
        axi_wr(REG_CTRL, 32'h0000_0000, AXI_OKAY);
        axi_rd(REG_STATUS, 32'h0000_0002, AXI_OKAY);
        axi_wr(REG_MASK, 32'h0000_0003, AXI_OKAY);
        chk({31'h0, irq}, 32'h0000_0001, "irq raised");
        axi_wr(REG_STATUS, 32'h0000_0002, AXI_OKAY);
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        // No short detection while pump disabled
        short_cmd <= 1'b1;
        repeat (2000) @(posedge clock_in);
        axi_rd(REG_FAULT, 32'h0000_0000, AXI_OKAY);
        axi_rd(REG_STATUS, 32'h0000_0000, AXI_OKAY);
        short_cmd <= 1'b0;
        $display("test interrupt done");
        // Short on a fully on gate
        axi_wr(REG_MASK, 32'h0000_0001, AXI_OKAY);
        axi_wr(REG_SETTING, 32'h0000_8008, AXI_OKAY);
        axi_wr(REG_CTRL, 32'h0000_0007, AXI_OKAY);
        repeat (8000) @(posedge clock_in);
        chk({30'h0, gate, fs}, 32'h0000_0003, "full on");
        short_cmd <= 1'b1;
        repeat (10) @(posedge clock_in);
        chk({29'h0, gate, fs, irq}, 32'h0000_0001, "short action");
        repeat (2000) @(posedge clock_in);
        short_cmd <= 1'b0;
        repeat (5) @(posedge clock_in);
        chk({30'h0, gate, fs}, 32'h0000_0000, "fault latched");
        axi_rd(REG_FAULT, 32'h0000_0001 << FAULT_PUMP_SHORT, AXI_OKAY);
        axi_rd(REG_FAULT, 32'h0000_0000, AXI_OKAY);
        repeat (8000) @(posedge clock_in);
        chk({30'h0, gate, fs}, 32'h0000_0003, "restart");
        axi_rd(REG_SETTING, 32'h0000_8008, AXI_OKAY);
        chk({31'h0, irq}, 32'h0000_0001, "sticky event");
        axi_wr(REG_STATUS, 32'h0000_0001, AXI_OKAY);
        chk({31'h0, irq}, 32'h0000_0000, "event cleared");
        $display("test short done");
        summarize();
    end
endmodule
